// ==== sdc_secfail_debug_capture.sv ====
// Security-fail fault code insertion into the check field, and a capture
// buffer for failing or first-per-association frames.
// Assumes frame words and their status come from same-clock datapath logic,
// already transformed, and a simple register port from the processor.
//
// Overview of operation
// R1 - Masks choose which counter events count as security failures.
// R2 - With debug on, failing frames leave with the check field replaced.
// R3 - Fault code uses 31 bits; bit 31 is always one.
// R4 - Bit 30 flags association hit; bits 29:24 then hold its pointer.
// R5 - Without hit: 29:27 zero, 26 control frame, 25:24 tag class.
// R6 - Bits 23:10 global event vector, bits 9:0 association event vector.
// R7 - Ingress global vector bits 0..13 follow the datapath event order.
// R8 - Ingress association vector bits 0..9 follow the datapath event order.
// R9 - Egress global vector uses bits 0..3; bits 13:4 are zero.
// R10 - Egress association vector uses bits 0..2; higher bits are zero.
// R11 - 512-byte buffer keeps at most 504 bytes of each failing packet.
// R12 - Association trigger bits request first-packet capture, self-clear on capture.
// R13 - Several packets stored in turn, each capped at programmed size.
// R14 - Side select picks egress or ingress frames for capture.
// R15 - Frames are captured as they leave the security transformation.
// R16 - Buffer readable as 128 indexed 32-bit words.
// R17 - Header word 0: reserved, truncation flag, 9-bit captured size.
// R18 - Truncation flag set when only part of packet was stored.
// R19 - Header word 1 holds the full 32-bit fault code.
// R20 - Status shows packet count, full flag and write pointer.
// R21 - Software arms all associations by writing all-ones to both words.
// R22 - Capture runs only while enabled; buffer readable only when stopped.
// R23 - Without room for header and packet, capture stops and full is set.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module sdc_secfail_debug_capture #(
    parameter int BUF_WORDS = sdc_pkg::BUF_WORDS
) (
    input  wire logic                       clk,           // Datapath clock
    input  wire logic                       rst_b,         // Async reset, low
    input  wire logic [11:0]                regAddr,       // Register byte address
    input  wire logic [31:0]                regWrData,     // Register write data
    input  wire logic                       regWr,         // Write strobe
    input  wire logic                       regRd,         // Read strobe
    output logic      [31:0]                regRdData,     // Read data, next cycle
    input  wire sdc_pkg::sdc_word_type   [1:0] wordIn,     // Frame words per side
    input  wire sdc_pkg::sdc_status_type [1:0] statIn,     // Frame status per side
    output logic      [1:0][31:0]           fcsOut,        // Check field per side
    output logic      [1:0]                 fcsOutValid,   // Check field strobe
    output logic      [1:0]                 failOut        // Frame failed, per side
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic                      dbgEn_reg;
    logic                      side_reg;
    logic [8:0]                maxSize_reg;
    logic                      trigEn_reg;
    logic [31:0]               trigLo_reg;
    logic [31:0]               trigHi_reg;
    logic [sdc_pkg::GLB_W-1:0] gMask_reg;
    logic [sdc_pkg::SAV_W-1:0] aMask_reg;
    logic [31:0]               regRdData_reg;
    logic [31:0]               mem [BUF_WORDS];

    // Capture state
    sdc_pkg::sdc_cap_state_type capState_reg;
    logic [7:0]                 wrPtr_reg;     // next free word, 0..128
    logic [7:0]                 base_reg;      // header slot of frame in work
    logic [7:0]                 slot_reg;      // next data slot of frame
    logic [8:0]                 bytes_reg;
    logic                       trunc_reg;
    logic [7:0]                 pktCount_reg;
    logic                       full_reg;

    // ------------------------------------------------------------------
    // Fault code per direction
    // ------------------------------------------------------------------
    logic [1:0][sdc_pkg::GLB_W-1:0] globVec;
    logic [1:0][sdc_pkg::SAV_W-1:0] assocVec;
    logic [1:0]                     failEvt;
    logic [1:0][31:0]               faultCode;
    logic [1:0]                     frameEnd;

    for (genvar d = 0; d < 2; d++) begin : g_dir
        if (d == sdc_pkg::DIR_EGRESS) begin : g_eg
            // R9 egress global zeroes
            assign globVec[d]  = {{(sdc_pkg::GLB_W - sdc_pkg::EG_GLB_USED){1'b0}},
                                  statIn[d].globalEvt[sdc_pkg::EG_GLB_USED-1:0]};
            // R10 egress association zeroes
            assign assocVec[d] = {{(sdc_pkg::SAV_W - sdc_pkg::EG_SAV_USED){1'b0}},
                                  statIn[d].assocEvt[sdc_pkg::EG_SAV_USED-1:0]};
        end else begin : g_in
            // R7 ingress global order
            assign globVec[d]  = statIn[d].globalEvt;
            // R8 ingress association order
            assign assocVec[d] = statIn[d].assocEvt;
        end
        // R1 masked failure events
        assign failEvt[d]  = (|(globVec[d] & gMask_reg)) | (|(assocVec[d] & aMask_reg));
        assign frameEnd[d] = wordIn[d].valid & wordIn[d].eof;
        // R3 R4 R5 R6 fault code layout
        assign faultCode[d] = {1'b1, statIn[d].saHit,
                               statIn[d].saHit ? statIn[d].saPtr
                                               : {3'b000, statIn[d].ctrlFrame,
                                                  statIn[d].tagClass},
                               globVec[d], assocVec[d]};

        // R2 check field replacement
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                fcsOut[d]      <= 32'h0000_0000;
                fcsOutValid[d] <= 1'b0;
                failOut[d]     <= 1'b0;
            end else begin
                fcsOutValid[d] <= frameEnd[d];
                if (frameEnd[d]) begin
                    fcsOut[d]  <= (dbgEn_reg && failEvt[d]) ? faultCode[d] : statIn[d].fcs;
                    failOut[d] <= failEvt[d];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Capture path on the selected side
    // ------------------------------------------------------------------
    // R14 side select
    sdc_pkg::sdc_word_type   capWord;
    sdc_pkg::sdc_status_type capStat;
    logic                    capFail;
    logic [31:0]             capCode;
    assign capWord = wordIn[side_reg];
    assign capStat = statIn[side_reg];
    assign capFail = failEvt[side_reg];
    assign capCode = faultCode[side_reg];

    // R12 first-packet request of the frame's association
    logic [63:0] trigAll;
    logic        trigHit;
    logic        capTrig;
    assign trigAll = {trigHi_reg, trigLo_reg};
    assign trigHit = capStat.saHit & trigAll[capStat.saPtr];
    assign capTrig = capFail | trigHit;

    // R11 per-packet limit never above 504 bytes
    logic [8:0] limitBytes;
    assign limitBytes = (maxSize_reg > 9'(sdc_pkg::CAP_LIMIT)) ? 9'(sdc_pkg::CAP_LIMIT)
                                                                : maxSize_reg;

    // R23 room for both header words and at least one data word
    logic roomOk;
    assign roomOk = (wrPtr_reg + 8'(sdc_pkg::HDR_WORDS)) < 8'(BUF_WORDS);

    // R15 capture taps the transformed stream; R22 only while enabled
    logic       isIdle;
    logic       startCap;
    logic       active;
    logic [8:0] curBytes;
    logic [7:0] curSlot;
    logic [7:0] curBase;
    logic       curTrunc;
    assign isIdle   = (capState_reg == sdc_pkg::CAP_IDLE);
    assign startCap = isIdle & capWord.valid & capWord.sof & trigEn_reg & ~full_reg & roomOk;
    assign active   = startCap | (~isIdle & capWord.valid & trigEn_reg);
    assign curBytes = isIdle ? 9'h000 : bytes_reg;
    assign curBase  = isIdle ? wrPtr_reg : base_reg;
    assign curSlot  = isIdle ? (wrPtr_reg + 8'(sdc_pkg::HDR_WORDS)) : slot_reg;
    assign curTrunc = isIdle ? 1'b0 : trunc_reg;

    // R13 bytes kept of this word, capped by programmed size and room
    logic [2:0] wordBytes;
    logic [8:0] leftBytes;
    logic       storeOk;
    logic [2:0] takeBytes;
    logic [8:0] newBytes;
    logic [7:0] newSlot;
    logic       newTrunc;
    logic       endCap;
    logic       commit;
    assign wordBytes = capWord.eof ? capWord.lastBytes : 3'h4;
    assign leftBytes = limitBytes - curBytes;
    assign storeOk   = active & (curBytes < limitBytes) & (curSlot < 8'(BUF_WORDS));
    assign takeBytes = !storeOk ? 3'h0
                     : (leftBytes < 9'(wordBytes)) ? leftBytes[2:0] : wordBytes;
    assign newBytes  = curBytes + 9'(takeBytes);
    assign newSlot   = curSlot + (storeOk ? 8'h01 : 8'h00);
    // R18 truncation when any byte was left out
    assign newTrunc  = curTrunc | (active & (takeBytes < wordBytes));
    assign endCap    = active & capWord.eof;
    assign commit    = endCap & capTrig;

    // R17 header word 0; R19 header word 1
    logic [31:0] hdrWord0;
    assign hdrWord0 = {22'h00_0000, newTrunc, newBytes};

    // Software writes and restart
    logic wrCtrl;
    logic wrTrig;
    logic wrTrigLo;
    logic wrTrigHi;
    logic restart;
    assign wrCtrl   = regWr & (regAddr == sdc_pkg::OFS_CTRL);
    assign wrTrig   = regWr & (regAddr == sdc_pkg::OFS_TRIG);
    assign wrTrigLo = regWr & (regAddr == sdc_pkg::OFS_TRIG_LO);
    assign wrTrigHi = regWr & (regAddr == sdc_pkg::OFS_TRIG_HI);
    assign restart  = wrTrig & regWrData[sdc_pkg::TRIG_RESTART_BIT];

    // Buffer storage, no reset: contents only matter behind the write pointer
    always_ff @(posedge clk) begin
        if (storeOk) begin
            mem[curSlot[6:0]] <= capWord.data;
        end
        if (commit) begin
            mem[curBase[6:0]]          <= hdrWord0;
            mem[7'(curBase + 8'h01)]   <= capCode;
        end
    end

    // Capture sequencing; a frame aborted by disable or no trigger is dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            capState_reg <= sdc_pkg::CAP_IDLE;
            base_reg     <= 8'h00;
            slot_reg     <= 8'h00;
            bytes_reg    <= 9'h000;
            trunc_reg    <= 1'b0;
        end else if (startCap && !capWord.eof) begin
            capState_reg <= sdc_pkg::CAP_STORE;
            base_reg     <= curBase;
            slot_reg     <= newSlot;
            bytes_reg    <= newBytes;
            trunc_reg    <= newTrunc;
        end else if (!isIdle && (endCap || !trigEn_reg)) begin
            capState_reg <= sdc_pkg::CAP_IDLE;
        end else if (!isIdle && active) begin
            slot_reg     <= newSlot;
            bytes_reg    <= newBytes;
            trunc_reg    <= newTrunc;
        end
    end

    // R20 status counters; R23 full stops further capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_reg    <= 8'h00;
            pktCount_reg <= 8'h00;
            full_reg     <= 1'b0;
        end else if (restart) begin
            wrPtr_reg    <= 8'h00;
            pktCount_reg <= 8'h00;
            full_reg     <= 1'b0;
        end else if (commit) begin
            wrPtr_reg    <= newSlot;
            pktCount_reg <= (pktCount_reg == 8'hFF) ? pktCount_reg : pktCount_reg + 8'h01;
            full_reg     <= (newSlot + 8'(sdc_pkg::HDR_WORDS)) >= 8'(BUF_WORDS);
        end else if (isIdle && capWord.valid && capWord.sof && trigEn_reg && !roomOk) begin
            full_reg     <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // R12 self-clear; a software write in the same cycle wins
    logic [63:0] trigClr;
    assign trigClr = (commit && capStat.saHit) ? (64'h0000_0000_0000_0001 << capStat.saPtr)
                                               : 64'h0000_0000_0000_0000;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dbgEn_reg   <= 1'b0;
            side_reg    <= 1'b0;
            maxSize_reg <= sdc_pkg::MAXSZ_RST;
            trigEn_reg  <= 1'b0;
            trigLo_reg  <= 32'h0000_0000;
            trigHi_reg  <= 32'h0000_0000;
            gMask_reg   <= 14'h0000;
            aMask_reg   <= 10'h000;
        end else begin
            if (wrCtrl) begin
                dbgEn_reg   <= regWrData[sdc_pkg::CTRL_DBG_EN_BIT];
                side_reg    <= regWrData[sdc_pkg::CTRL_SIDE_BIT];
                maxSize_reg <= regWrData[sdc_pkg::CTRL_MAXSZ_LSB +: 9];
            end
            // R22 capture enable
            if (wrTrig) begin
                trigEn_reg <= regWrData[sdc_pkg::TRIG_EN_BIT];
            end
            // R21 software arms associations
            trigLo_reg <= wrTrigLo ? regWrData : (trigLo_reg & ~trigClr[31:0]);
            trigHi_reg <= wrTrigHi ? regWrData : (trigHi_reg & ~trigClr[63:32]);
            if (regWr && regAddr == sdc_pkg::OFS_GMASK) begin
                gMask_reg <= regWrData[sdc_pkg::GLB_W-1:0];
            end
            if (regWr && regAddr == sdc_pkg::OFS_AMASK) begin
                aMask_reg <= regWrData[sdc_pkg::SAV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // R16 indexed word window, open only while capture is stopped
    logic        inWindow;
    logic [6:0]  winIdx;
    logic [31:0] rdMux;
    logic [31:0] statusWord;
    assign inWindow   = (regAddr >= sdc_pkg::OFS_WINDOW)
                      && (regAddr < sdc_pkg::OFS_WINDOW + 12'(BUF_WORDS * 4))
                      && (regAddr[1:0] == 2'b00);
    assign winIdx     = 7'(regAddr[8:2]);
    // R20 status layout
    assign statusWord = {8'h00, wrPtr_reg, 7'h00, full_reg, pktCount_reg};
    assign rdMux = (regAddr == sdc_pkg::OFS_CTRL)    ? {15'h0000, maxSize_reg, 6'h00,
                                                         side_reg, dbgEn_reg}
                 : (regAddr == sdc_pkg::OFS_TRIG)    ? {31'h0000_0000, trigEn_reg}
                 : (regAddr == sdc_pkg::OFS_TRIG_LO) ? trigLo_reg
                 : (regAddr == sdc_pkg::OFS_TRIG_HI) ? trigHi_reg
                 : (regAddr == sdc_pkg::OFS_STATUS)  ? statusWord
                 : (regAddr == sdc_pkg::OFS_GMASK)   ? {18'h0_0000, gMask_reg}
                 : (regAddr == sdc_pkg::OFS_AMASK)   ? {22'h00_0000, aMask_reg}
                 : (inWindow && !trigEn_reg)         ? mem[winIdx]
                 : 32'h0000_0000;

    // Read data stands for one cycle only; zero otherwise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData_reg <= 32'h0000_0000;
        end else begin
            regRdData_reg <= regRd ? rdMux : 32'h0000_0000;
        end
    end
    assign regRdData = regRdData_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_fault_insert;
        @(posedge clk) disable iff (!rst_b)
        (frameEnd[0] && dbgEn_reg && failEvt[0]) |=> (fcsOut[0] == $past(faultCode[0]));
    endproperty
    a_fault_insert: assert property (p_fault_insert) // R2
        else $error("failing frame kept its check field");

    property p_pass_through;
        @(posedge clk) disable iff (!rst_b)
        (frameEnd[1] && !(dbgEn_reg && failEvt[1])) |=> (fcsOut[1] == $past(statIn[1].fcs));
    endproperty
    a_pass_through: assert property (p_pass_through) // R1
        else $error("passing frame had its check field changed");

    property p_reserved_bit;
        @(posedge clk) disable iff (!rst_b)
        fcsOutValid[0] && failOut[0] && $past(dbgEn_reg) |-> fcsOut[0][31];
    endproperty
    a_reserved_bit: assert property (p_reserved_bit) // R3
        else $error("fault code top bit not set");

    property p_egress_zero;
        @(posedge clk) disable iff (!rst_b)
        frameEnd[1] && dbgEn_reg && failEvt[1] |=> !(|{fcsOut[1][23:14], fcsOut[1][9:3]});
    endproperty
    a_egress_zero: assert property (p_egress_zero) // R9
        else $error("egress reserved vector bits not zero");

    property p_trigger_clear;
        @(posedge clk) disable iff (!rst_b)
        (commit && capStat.saHit && !wrTrigLo && !wrTrigHi) |=> !trigAll[$past(capStat.saPtr)];
    endproperty
    a_trigger_clear: assert property (p_trigger_clear) // R12
        else $error("association trigger bit not cleared after capture");

    property p_count_step;
        @(posedge clk) disable iff (!rst_b)
        (commit && !restart && pktCount_reg != 8'hFF) |=> (pktCount_reg == $past(pktCount_reg) + 8'h01);
    endproperty
    a_count_step: assert property (p_count_step) // R20
        else $error("packet count did not advance on capture");

    property p_size_cap;
        @(posedge clk) disable iff (!rst_b)
        commit |-> (newBytes <= limitBytes) && (limitBytes <= 9'(sdc_pkg::CAP_LIMIT));
    endproperty
    a_size_cap: assert property (p_size_cap) // R11
        else $error("captured size above limit");

    property p_full_holds;
        @(posedge clk) disable iff (!rst_b)
        (full_reg && !restart) |=> full_reg && $stable(wrPtr_reg) && (wrPtr_reg <= 8'(BUF_WORDS));
    endproperty
    a_full_holds: assert property (p_full_holds) // R23
        else $error("capture went on after buffer full");

    property p_disabled_idle;
        @(posedge clk) disable iff (!rst_b)
        !trigEn_reg ##1 !trigEn_reg |-> !commit && isIdle;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) // R22
        else $error("capture active while disabled");

endmodule : sdc_secfail_debug_capture

// ==== sdc_pkg.sv ====
// Shared constants and types of the security-fail debug capture block.
// Assumes one clock domain shared with the security datapath that feeds it.
package sdc_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int WORD_W        = 32;
    localparam int BUF_WORDS     = 128;   // 512 bytes seen as 128 words
    localparam int HDR_WORDS     = 2;     // 64-bit administration header
    localparam int CAP_LIMIT     = 504;   // most bytes kept of one packet
    localparam int ADDR_W        = 12;
    localparam int GLB_W         = 14;
    localparam int SAV_W         = 10;
    localparam int EG_GLB_USED   = 4;     // egress global events in use
    localparam int EG_SAV_USED   = 3;     // egress association events in use
    localparam int DIR_INGRESS   = 0;
    localparam int DIR_EGRESS    = 1;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_TRIG     = 12'h004;
    localparam logic [11:0] OFS_TRIG_LO  = 12'h008;
    localparam logic [11:0] OFS_TRIG_HI  = 12'h00C;
    localparam logic [11:0] OFS_STATUS   = 12'h010;
    localparam logic [11:0] OFS_GMASK    = 12'h014;
    localparam logic [11:0] OFS_AMASK    = 12'h018;
    localparam logic [11:0] OFS_WINDOW   = 12'h200;  // 128 words up to 0x3FC

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_DBG_EN_BIT   = 0;
    localparam int CTRL_SIDE_BIT     = 1;
    localparam int CTRL_MAXSZ_LSB    = 8;
    localparam int TRIG_EN_BIT       = 0;
    localparam int TRIG_RESTART_BIT  = 1;
    localparam int STAT_FULL_BIT     = 8;
    localparam int STAT_WRPTR_LSB    = 16;
    localparam int HDR_TRUNC_BIT     = 9;
    localparam logic [8:0] MAXSZ_RST = 9'h1F8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TAG_UNTAGGED = 2'b00,
        TAG_TAGGED   = 2'b01,
        TAG_BAD      = 2'b10,
        TAG_KEYAGREE = 2'b11
    } sdc_tag_type;

    typedef enum logic {CAP_IDLE, CAP_STORE} sdc_cap_state_type;

    // One word of a frame after the security transformation
    typedef struct packed {
        logic        valid;
        logic        sof;
        logic        eof;
        logic [2:0]  lastBytes;  // 1..4 valid bytes in the eof word
        logic [31:0] data;
    } sdc_word_type;

    // Classification and events of a frame, valid beside its eof word
    typedef struct packed {
        logic              saHit;
        logic [5:0]        saPtr;
        logic              ctrlFrame;
        sdc_tag_type       tagClass;
        logic [GLB_W-1:0]  globalEvt;
        logic [SAV_W-1:0]  assocEvt;
        logic [31:0]       fcs;
    } sdc_status_type;

endpackage : sdc_pkg

// ==== test_secfail_debug_capture.sv ====
// Self-checking bench for the security-fail fault code and capture buffer.
// Assumes the design package is compiled first; one clock, one register port.
`timescale 1ns/1ns
module test_secfail_debug_capture;
    logic                          clk = 1'b0;
    logic                          rst_b = 1'b0;
    logic                          regWr = 1'b0;
    logic                          regRd = 1'b0;
    logic                          rdPend = 1'b0;
    logic [11:0]                   regAddr = 12'h000;
    logic [31:0]                   regWrData = 32'h0000_0000;
    logic [31:0]                   regRdData;
    sdc_pkg::sdc_word_type   [1:0] wordIn = '0;
    sdc_pkg::sdc_status_type [1:0] statIn = '0;
    logic [1:0][31:0]              fcsOut;
    logic [1:0]                    fcsOutValid;
    logic [1:0]                    failOut;
    logic [31:0]                   rq[$];
    logic [32:0]                   fq[$];
    logic [31:0]                   dat[4];
    int                            errors = 0;
    int                            n_compared = 0;

    sdc_secfail_debug_capture u_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .wordIn(wordIn), .statIn(statIn), .fcsOut(fcsOut), .fcsOutValid(fcsOutValid),
        .failOut(failOut));

    // 250 MHz clock
    always #2 clk = ~clk;

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Results are compared in the cycle they stand, oldest note first
    always @(posedge clk) begin
        if (rdPend) check({1'b0, regRdData}, {1'b0, rq.pop_front()});
        rdPend <= regRd;
        for (int d = 0; d < 2; d++)
            if (fcsOutValid[d] === 1'b1) check({failOut[d], fcsOut[d]}, fq.pop_front());
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        regAddr   <= a;
        regWrData <= v;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr     <= 1'b0;
        @(posedge clk);  // Idle edge so the next strobe is not set twice in one step
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        @(posedge clk);
    endtask : rd

    // Frame of n words from dat, status beside every word, result noted first
    task automatic frame(input int d, input int n, input logic [2:0] lb,
                         input sdc_pkg::sdc_status_type s, input logic [32:0] e);
        fq.push_back(e);
        for (int i = 0; i < n; i++) begin
            wordIn[d] <= '{1'b1, i == 0, i == n - 1, lb, dat[i]};
            statIn[d] <= s;
            @(posedge clk);
        end
        wordIn[d] <= '0;
        @(posedge clk);
    endtask : frame

    // Egress leaves unused vector bits at zero, which matters here
    function automatic logic [31:0] code(input sdc_pkg::sdc_status_type s, input int d);
        logic [13:0] g;
        logic [9:0]  a;
        g = (d == 1) ? {10'h000, s.globalEvt[3:0]} : s.globalEvt;
        a = (d == 1) ? {7'h00, s.assocEvt[2:0]} : s.assocEvt;
        return {1'b1, s.saHit, s.saHit ? s.saPtr : {3'b000, s.ctrlFrame, s.tagClass}, g, a};
    endfunction : code

    task automatic finish_test();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    initial begin
        sdc_pkg::sdc_status_type s;
        void'($urandom(8434));
        foreach (dat[i]) dat[i] = $urandom;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(sdc_pkg::OFS_STATUS, 32'h0000_0000);
        rd(sdc_pkg::OFS_CTRL, 32'h0001_F800);
        rd(12'h020, 32'h0000_0000);
        wr(sdc_pkg::OFS_CTRL, 32'h0001_F801);
        wr(sdc_pkg::OFS_GMASK, 32'h0000_3FFF);
        wr(sdc_pkg::OFS_AMASK, 32'h0000_03FF);
        // every tag class, hits on egress
        for (int t = 0; t < 8; t++) begin
            s = {2'(t), $urandom, $urandom};
            s.saHit = t[2];
            s.tagClass = sdc_pkg::sdc_tag_type'(t[1:0]);
            s.globalEvt[0] = 1'b1;
            frame(t / 4, 1 + t % 3, 3'd4, s, {1'b1, code(s, t / 4)});
        end
        $display("fault code test done");
        wr(sdc_pkg::OFS_TRIG, 32'h0000_0001);
        rd(sdc_pkg::OFS_WINDOW, 32'h0000_0000);
        s.saHit = 1'b0;
        frame(0, 3, 3'd2, s, {1'b1, code(s, 0)});
        wr(sdc_pkg::OFS_TRIG, 32'h0000_0000);
        rd(sdc_pkg::OFS_STATUS, 32'h0005_0001);
        rd(sdc_pkg::OFS_WINDOW, 32'h0000_000A);
        rd(sdc_pkg::OFS_WINDOW + 12'h004, code(s, 0));
        for (int i = 0; i < 3; i++) rd(sdc_pkg::OFS_WINDOW + 12'(8 + 4 * i), dat[i]);
        // size cap of four bytes truncates
        wr(sdc_pkg::OFS_CTRL, 32'h0000_0401);
        wr(sdc_pkg::OFS_TRIG, 32'h0000_0003);
        frame(0, 3, 3'd4, s, {1'b1, code(s, 0)});
        wr(sdc_pkg::OFS_TRIG, 32'h0000_0000);
        rd(sdc_pkg::OFS_WINDOW, 32'h0000_0204);
        $display("capture test done");
        wr(sdc_pkg::OFS_GMASK, 32'h0000_0000);
        wr(sdc_pkg::OFS_AMASK, 32'h0000_0000);
        wr(sdc_pkg::OFS_TRIG_LO, 32'h0000_0001);
        wr(sdc_pkg::OFS_TRIG, 32'h0000_0003);
        s.saHit = 1'b1;
        s.saPtr = 6'd1;
        frame(0, 1, 3'd4, s, {1'b0, s.fcs});
        s.saPtr = 6'd0;
        frame(0, 1, 3'd4, s, {1'b0, s.fcs});
        wr(sdc_pkg::OFS_TRIG, 32'h0000_0000);
        rd(sdc_pkg::OFS_TRIG_LO, 32'h0000_0000);
        rd(sdc_pkg::OFS_STATUS, 32'h0003_0001);
        $display("trigger test done");
        // egress side captured, ingress ignored; passing frames keep their check field
        wr(sdc_pkg::OFS_CTRL, 32'h0001_F803);
        wr(sdc_pkg::OFS_TRIG_LO, 32'h0000_0001);
        wr(sdc_pkg::OFS_TRIG, 32'h0000_0003);
        frame(0, 1, 3'd4, s, {1'b0, s.fcs});
        frame(1, 2, 3'd3, s, {1'b0, s.fcs});
        wr(sdc_pkg::OFS_TRIG, 32'h0000_0000);
        rd(sdc_pkg::OFS_STATUS, 32'h0004_0001);
        rd(sdc_pkg::OFS_WINDOW, 32'h0000_0007);
        rd(sdc_pkg::OFS_WINDOW + 12'h004, code(s, 1));
        rd(sdc_pkg::OFS_TRIG_LO, 32'h0000_0000);
        $display("side test done");
        // Bounded drain of outstanding notes
        for (int i = 0; i < 8 && (rq.size() + fq.size()) > 0; i++) @(posedge clk);
        if ((rq.size() + fq.size()) > 0) errors++;
        finish_test();
    end
endmodule : test_secfail_debug_capture
